// ---- timer_split_pkg.sv ----
// package: register map, field layout and shared types for the split-capable timer
package timer_split_pkg;

  // ==========================================================================
  // register byte addresses (one 32-bit word each)
  localparam logic [7:0] first_control_register_addr  = 8'h00;
  localparam logic [7:0] fourth_control_register_addr = 8'h0C;
  localparam logic [7:0] command_set_register_addr    = 8'h14;
  localparam logic [7:0] event_control_addr           = 8'h24;
  localparam logic [7:0] irq_enable_register_addr     = 8'h28;
  localparam logic [7:0] irq_flag_register_addr       = 8'h2C;
  localparam logic [7:0] sleep_control_addr           = 8'h38;
  localparam logic [7:0] count_addr                   = 8'h80;
  localparam logic [7:0] period_addr                  = 8'h98;
  localparam logic [7:0] match0_addr                  = 8'hA0;
  localparam logic [7:0] match1_addr                  = 8'hA8;
  localparam logic [7:0] match2_addr                  = 8'hB0;

  // ==========================================================================
  // field positions
  localparam int run_en_bit       = 0;
  localparam int prescale_lsb     = 1;
  localparam int standby_run_bit  = 7;
  localparam int dual_byte_bit    = 0;
  localparam int cmd_lsb          = 2;
  localparam int a_enable_bit     = 0;
  localparam int a_action_lsb     = 1;
  localparam int b_enable_bit     = 4;
  localparam int b_action_lsb     = 5;
  localparam int wrap_bit         = 0;
  localparam int upper_unf_bit    = 1;
  localparam int match_lsb        = 4;
  localparam int standby_req_bit  = 0;
  localparam int powerdown_req_bit = 1;

  // ==========================================================================
  // reset values and encodings
  localparam logic [15:0] period_reset = 16'hFFFF;
  localparam logic [1:0]  cmd_restart  = 2'h2;
  localparam logic [1:0]  cmd_reset    = 2'h3;
  localparam logic [31:0] read_zero    = 32'h0000_0000;

  // event input actions
  localparam logic [2:0] act_a_none  = 3'h0;
  localparam logic [2:0] act_a_rise  = 3'h1;
  localparam logic [2:0] act_a_any   = 3'h2;
  localparam logic [2:0] act_a_high  = 3'h3;
  localparam logic [2:0] act_a_dir   = 3'h4;
  localparam logic [2:0] act_b_none  = 3'h0;
  localparam logic [2:0] act_b_dir   = 3'h3;
  localparam logic [2:0] act_b_rise  = 3'h4;
  localparam logic [2:0] act_b_any   = 3'h5;
  localparam logic [2:0] act_b_high  = 3'h6;

  // the five event pulses that leave the block
  typedef struct packed {
    logic       wrap_or_low_underflow_event;
    logic       upper_byte_underflow;
    logic [2:0] match_event;
  } events_s;

  // complete register state of the timer
  typedef struct packed {
    logic        run_en;
    logic [2:0]  prescale_select;
    logic        standby_run_enable;
    logic        dual_byte_mode_enable;
    logic        input_a_enable;
    logic [2:0]  input_a_action;
    logic        input_b_enable;
    logic [2:0]  input_b_action;
    logic [4:0]  irq_enable;
    logic [4:0]  irq_flag;
    logic [15:0] count;
    logic        count_down;
    logic [15:0] period;
    logic [15:0] match0;
    logic [15:0] match1;
    logic [15:0] match2;
    logic [9:0]  prescale_count;
    logic        a_prev;
    logic        b_prev;
    events_s     events;
    logic [31:0] prdata;
  } state_s;

endpackage

// ---- timer_split.sv ----
// timer_split: 16-bit timer / dual 8-bit down-counter with events, irq and sleep gating
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - mode switch keeps every register value
// - enabled counter advances on selected prescaler tick
// - counter registers readable during split operation
// - shared events reinterpret meaning by mode
// - upper underflow event only in split
// - every event lasts one clock exactly
// - events fire on same conditions as flags
// - input a: rise, any edge, high, direction
// - input b: direction, restart rise/any/high
// - action field selects; enable bit gates input
// - both direction inputs ORed, up when low
// - event inputs ignored in split mode
// - normal: wrap at top/bottom, compare matches
// - split: byte underflows, low compare matches
// - flags set regardless of enable bits
// - irq while enabled flag set, until cleared
// - standby halts counting by default
// - standby run bit keeps timer running
// - power-down halts prescaler and counting
// - restart clears count and direction
// - split counts down single slope only
// - prescale codes divide by 1..1024
module timer_split (
  input  wire logic                    pclk,          // 40 MHz peripheral clock
  input  wire logic                    presetn,       // async reset, active low
  input  wire logic                    psel,          // apb select
  input  wire logic                    penable,       // apb access phase
  input  wire logic                    pwrite,        // apb direction
  input  wire logic [7:0]              paddr,         // apb byte address
  input  wire logic [31:0]             pwdata,        // apb write data
  input  wire logic [3:0]              pstrb,         // apb byte strobes
  output logic                         pready,        // always ready
  output logic [31:0]                  prdata,        // registered read data
  output logic                         pslverr,       // unmapped access
  input  wire logic                    standby_sleep, // standby sleep active
  input  wire logic                    powerdown_sleep, // power-down sleep active
  input  wire logic                    event_input_a, // event network input a
  input  wire logic                    event_input_b, // event network input b
  output timer_split_pkg::events_s     events,        // one-cycle event pulses
  output logic                         irq            // level interrupt request
);

  // ==========================================================================
  // state and helpers
  timer_split_pkg::state_s state;
  timer_split_pkg::state_s next_state;
  logic a_sync1;
  logic a_sync2;
  logic b_sync1;
  logic b_sync2;
  logic standby_sync1;
  logic standby_sync2;
  logic pdown_sync1;
  logic pdown_sync2;

  // divider ratio per prescale code, as a mask of the low count bits
  function automatic logic [9:0] prescale_mask(input logic [2:0] sel);
    case (sel)
      3'h0:    prescale_mask = 10'h000;
      3'h1:    prescale_mask = 10'h001;
      3'h2:    prescale_mask = 10'h003;
      3'h3:    prescale_mask = 10'h007;
      3'h4:    prescale_mask = 10'h00F;
      3'h5:    prescale_mask = 10'h03F;
      3'h6:    prescale_mask = 10'h0FF;
      default: prescale_mask = 10'h3FF;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == timer_split_pkg::first_control_register_addr) ||
             (a == timer_split_pkg::fourth_control_register_addr) ||
             (a == timer_split_pkg::command_set_register_addr) ||
             (a == timer_split_pkg::event_control_addr) ||
             (a == timer_split_pkg::irq_enable_register_addr) ||
             (a == timer_split_pkg::irq_flag_register_addr) ||
             (a == timer_split_pkg::sleep_control_addr) ||
             (a == timer_split_pkg::count_addr) ||
             (a == timer_split_pkg::period_addr) ||
             (a == timer_split_pkg::match0_addr) ||
             (a == timer_split_pkg::match1_addr) ||
             (a == timer_split_pkg::match2_addr);
  endfunction

  // ==========================================================================
  // synchronisers for pins from other domains
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_sync1       <= 1'b0;
      a_sync2       <= 1'b0;
      b_sync1       <= 1'b0;
      b_sync2       <= 1'b0;
      standby_sync1 <= 1'b0;
      standby_sync2 <= 1'b0;
      pdown_sync1   <= 1'b0;
      pdown_sync2   <= 1'b0;
    end else begin
      a_sync1       <= event_input_a;
      a_sync2       <= a_sync1;
      b_sync1       <= event_input_b;
      b_sync2       <= b_sync1;
      standby_sync1 <= standby_sleep;
      standby_sync2 <= standby_sync1;
      pdown_sync1   <= powerdown_sleep;
      pdown_sync2   <= pdown_sync1;
    end
  end

  // ==========================================================================
  // apb access decode; no wait states
  logic        access;
  logic        wr;
  logic [31:0] wmask;
  assign access  = psel && penable;
  assign wr      = access && pwrite;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped(paddr);
  assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // combinational working values
  logic        halted;
  logic        tick;
  logic        a_on;
  logic        b_on;
  logic        a_rise;
  logic        a_any;
  logic        b_rise;
  logic        b_any;
  logic        a_dir;
  logic        b_dir;
  logic        step;
  logic        restart;
  logic        dir_down;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic [4:0]  cond;
  logic [4:0]  clr;
  logic [31:0] wv;

  // ==========================================================================
  // next-state logic: counting, events, flags and register writes
  always_comb begin
    next_state = state;
    next_state.events = '0;
    cond = 5'h00;
    clr  = 5'h00;
    wv   = pwdata & wmask;
    // power-down always stops; standby stops unless told to run
    halted = pdown_sync2 || (standby_sync2 && !state.standby_run_enable);
    tick = state.run_en && !halted &&
           ((state.prescale_count & prescale_mask(state.prescale_select)) == 10'h000);
    // event inputs only in normal mode and only when enabled
    a_on   = state.input_a_enable && !state.dual_byte_mode_enable;
    b_on   = state.input_b_enable && !state.dual_byte_mode_enable;
    a_rise = a_sync2 && !state.a_prev;
    a_any  = a_sync2 != state.a_prev;
    b_rise = b_sync2 && !state.b_prev;
    b_any  = b_sync2 != state.b_prev;
    a_dir  = a_on && (state.input_a_action == timer_split_pkg::act_a_dir);
    b_dir  = b_on && (state.input_b_action == timer_split_pkg::act_b_dir);
    // step decides whether a tick counts; counting actions gate plain ticks
    step = tick;
    if (a_on) begin
      case (state.input_a_action)
        timer_split_pkg::act_a_rise: step = tick && a_rise;
        timer_split_pkg::act_a_any:  step = tick && a_any;
        timer_split_pkg::act_a_high: step = tick && a_sync2;
        default:                     step = tick;
      endcase
    end
    restart = 1'b0;
    if (b_on) begin
      case (state.input_b_action)
        timer_split_pkg::act_b_rise: restart = b_rise;
        timer_split_pkg::act_b_any:  restart = b_any;
        timer_split_pkg::act_b_high: restart = b_sync2;
        default:                     restart = 1'b0;
      endcase
    end
    dir_down = state.count_down;
    if (a_dir || b_dir) begin
      dir_down = (a_dir && a_sync2) || (b_dir && b_sync2);
    end
    next_state.count_down = dir_down;
    next_state.a_prev = a_sync2;
    next_state.b_prev = b_sync2;
    if (state.run_en && !halted) begin
      next_state.prescale_count = state.prescale_count + 10'h001;
    end
    lo = state.count[7:0];
    hi = state.count[15:8];
    // counting: registers keep their values across a mode change, only meaning differs
    if (step && !restart) begin
      if (state.dual_byte_mode_enable) begin
        next_state.count[7:0]  = (lo == 8'h00) ? state.period[7:0] : lo - 8'h01;
        next_state.count[15:8] = (hi == 8'h00) ? state.period[15:8] : hi - 8'h01;
        cond[0] = (lo == 8'h00);
        cond[1] = (hi == 8'h00);
        cond[2] = (lo == state.match0[7:0]);
        cond[3] = (lo == state.match1[7:0]);
        cond[4] = (lo == state.match2[7:0]);
      end else begin
        if (dir_down) begin
          next_state.count = (state.count == 16'h0000) ? state.period : state.count - 16'h0001;
          cond[0] = (state.count == 16'h0000);
        end else begin
          next_state.count = (state.count >= state.period) ? 16'h0000 : state.count + 16'h0001;
          cond[0] = (state.count >= state.period);
        end
        cond[2] = (state.count == state.match0);
        cond[3] = (state.count == state.match1);
        cond[4] = (state.count == state.match2);
      end
    end
    if (restart) begin
      next_state.count      = 16'h0000;
      next_state.count_down = 1'b0;
    end
    // events share the flag conditions and last one clock
    next_state.events.wrap_or_low_underflow_event = cond[0];
    next_state.events.upper_byte_underflow        = cond[1];
    next_state.events.match_event                 = cond[4:2];
    // register writes
    if (wr) begin
      case (paddr)
        timer_split_pkg::first_control_register_addr: begin
          next_state.run_en             = wv[timer_split_pkg::run_en_bit];
          next_state.prescale_select    = wv[timer_split_pkg::prescale_lsb +: 3];
          next_state.standby_run_enable = wv[timer_split_pkg::standby_run_bit];
        end
        timer_split_pkg::fourth_control_register_addr: begin
          next_state.dual_byte_mode_enable = wv[timer_split_pkg::dual_byte_bit];
        end
        timer_split_pkg::command_set_register_addr: begin
          if (wv[timer_split_pkg::cmd_lsb +: 2] == timer_split_pkg::cmd_restart) begin
            next_state.count      = 16'h0000;
            next_state.count_down = 1'b0;
          end else if (wv[timer_split_pkg::cmd_lsb +: 2] == timer_split_pkg::cmd_reset && !state.run_en) begin
            next_state = '0;
            next_state.period = timer_split_pkg::period_reset;
            next_state.a_prev = a_sync2;
            next_state.b_prev = b_sync2;
          end
        end
        timer_split_pkg::event_control_addr: begin
          next_state.input_a_enable = wv[timer_split_pkg::a_enable_bit];
          next_state.input_a_action = wv[timer_split_pkg::a_action_lsb +: 3];
          next_state.input_b_enable = wv[timer_split_pkg::b_enable_bit];
          next_state.input_b_action = wv[timer_split_pkg::b_action_lsb +: 3];
        end
        timer_split_pkg::irq_enable_register_addr: next_state.irq_enable = wv[4:0];
        timer_split_pkg::irq_flag_register_addr:   clr = wv[4:0];
        timer_split_pkg::count_addr:  next_state.count  = wv[15:0];
        timer_split_pkg::period_addr: next_state.period = wv[15:0];
        timer_split_pkg::match0_addr: next_state.match0 = wv[15:0];
        timer_split_pkg::match1_addr: next_state.match1 = wv[15:0];
        timer_split_pkg::match2_addr: next_state.match2 = wv[15:0];
        default: ;
      endcase
    end
    // flags set regardless of enables; a set beats a same-cycle clear
    next_state.irq_flag = (next_state.irq_flag & ~clr) | cond;
    // read data captured at the end of setup, so it stands through the access phase
    next_state.prdata = timer_split_pkg::read_zero;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        timer_split_pkg::first_control_register_addr:
          next_state.prdata = {24'h0, state.standby_run_enable, 3'h0, state.prescale_select, state.run_en};
        timer_split_pkg::fourth_control_register_addr: next_state.prdata = {31'h0, state.dual_byte_mode_enable};
        timer_split_pkg::event_control_addr:
          next_state.prdata = {24'h0, state.input_b_action, state.input_b_enable,
                               state.input_a_action, state.input_a_enable};
        timer_split_pkg::irq_enable_register_addr: next_state.prdata = {27'h0, state.irq_enable};
        timer_split_pkg::irq_flag_register_addr:   next_state.prdata = {27'h0, state.irq_flag};
        timer_split_pkg::sleep_control_addr:       next_state.prdata = {30'h0, pdown_sync2, standby_sync2};
        timer_split_pkg::count_addr:  next_state.prdata = {15'h0, state.count_down, state.count};
        timer_split_pkg::period_addr: next_state.prdata = {16'h0, state.period};
        timer_split_pkg::match0_addr: next_state.prdata = {16'h0, state.match0};
        timer_split_pkg::match1_addr: next_state.prdata = {16'h0, state.match1};
        timer_split_pkg::match2_addr: next_state.prdata = {16'h0, state.match2};
        default: next_state.prdata = timer_split_pkg::read_zero;
      endcase
    end else begin
      next_state.prdata = state.prdata;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= '0;
      state.period <= timer_split_pkg::period_reset;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  assign events = state.events;
  assign prdata = state.prdata;
  assign irq    = |(state.irq_flag & state.irq_enable);

  // ==========================================================================
  // assertions
  chk_event_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    events.wrap_or_low_underflow_event |=> !events.wrap_or_low_underflow_event)
    else $error("wrap event longer than one cycle");
  chk_upper_split_only: assert property (@(posedge pclk) disable iff (!presetn)
    events.upper_byte_underflow |-> $past(state.dual_byte_mode_enable))
    else $error("upper underflow outside split mode");
  chk_event_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    events.match_event[0] |-> state.irq_flag[2])
    else $error("match event without its flag");
  chk_flag_no_enable: assert property (@(posedge pclk) disable iff (!presetn)
    events.wrap_or_low_underflow_event |-> state.irq_flag[0])
    else $error("wrap flag not set");
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (state.irq_flag[0] && state.irq_enable[0]) |-> irq)
    else $error("irq missing for enabled flag");
  chk_powerdown_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (pdown_sync2 && $stable(pdown_sync2) && !wr) |=> $stable(state.prescale_count))
    else $error("timer ran in power-down");
  chk_split_down: assert property (@(posedge pclk) disable iff (!presetn)
    (state.dual_byte_mode_enable && !wr && state.count[7:0] != 8'h00)
    |=> (state.count[7:0] == $past(state.count[7:0]) || state.count[7:0] == $past(state.count[7:0]) - 8'h01))
    else $error("split low byte counted up");
  chk_split_no_events: assert property (@(posedge pclk) disable iff (!presetn)
    (state.dual_byte_mode_enable && !wr) |=> !$past(restart))
    else $error("event input acted in split mode");
  chk_clear_by_one: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == timer_split_pkg::irq_flag_register_addr && pstrb[0] && pwdata[0] && !cond[0])
    |=> !state.irq_flag[0])
    else $error("flag not cleared by write of one");

endmodule // timer_split

`default_nettype wire

// ---- event_net_model.sv ----
// partner model: event routing network and event pulse counters facing the timer
`timescale 1ns/1ps
`default_nettype none
module event_net_model (
  input  wire logic                     pclk,          // peripheral clock
  input  wire logic                     presetn,       // async reset, active low
  input  wire logic                     a_level,       // level wanted on input a
  input  wire logic                     b_level,       // level wanted on input b
  input  wire timer_split_pkg::events_s events,        // pulses from the timer
  output logic                          event_input_a, // routed input a
  output logic                          event_input_b, // routed input b
  output int                            wrap_seen,     // wrap or low underflow pulses
  output int                            upper_seen,    // upper underflow pulses
  output int                            match_seen,    // pulses on any match line
  output int                            long_seen      // pulses held past one cycle
);
  timer_split_pkg::events_s prev;

  // ==========================================================================
  // routing and pulse watch
  // levels move at most once a cycle, so level actions stay slower than ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_input_a <= 1'b0;
      event_input_b <= 1'b0;
      prev          <= '0;
      wrap_seen     <= 0;
      upper_seen    <= 0;
      match_seen    <= 0;
      long_seen     <= 0;
    end else begin
      event_input_a <= a_level;
      event_input_b <= b_level;
      prev          <= events;
      wrap_seen     <= wrap_seen + int'(events.wrap_or_low_underflow_event);
      upper_seen    <= upper_seen + int'(events.upper_byte_underflow);
      match_seen    <= match_seen + int'(events.match_event != 3'h0);
      long_seen     <= long_seen + int'((events & prev) != 5'h00);
    end
  end
endmodule // event_net_model
`default_nettype wire

// ---- tb_top.sv ----
// tb_top: self-checking bench for the split-capable timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_s;
  localparam logic [7:0] a_ctrl  = timer_split_pkg::first_control_register_addr;
  localparam logic [7:0] a_split = timer_split_pkg::fourth_control_register_addr;
  localparam logic [7:0] a_cmd   = timer_split_pkg::command_set_register_addr;
  localparam logic [7:0] a_evc   = timer_split_pkg::event_control_addr;
  localparam logic [7:0] a_ien   = timer_split_pkg::irq_enable_register_addr;
  localparam logic [7:0] a_flag  = timer_split_pkg::irq_flag_register_addr;
  localparam logic [7:0] a_cnt   = timer_split_pkg::count_addr;
  localparam logic [7:0] a_per   = timer_split_pkg::period_addr;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, irq;
  logic                     standby_sleep, powerdown_sleep, a_level, b_level, ev_a, ev_b;
  logic [7:0]               paddr;
  logic [3:0]               pstrb;
  logic [31:0]              pwdata, prdata, rdata;
  logic [15:0]              dc;
  timer_split_pkg::events_s events;
  int                       fail_count, checks, cycles, wrap_seen, upper_seen, match_seen, long_seen, up0;
  int                       divs [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  row_s                     rows [8] = '{'{a_per, 1'b0, 32'h0, 32'h0000_FFFF}, '{a_flag, 1'b0, 32'h0, 32'h0},
    '{a_per, 1'b1, 32'h0000_ABCD, 32'h0000_ABCD}, '{timer_split_pkg::match0_addr, 1'b1, 32'h3, 32'h3},
    '{timer_split_pkg::match1_addr, 1'b1, 32'h5, 32'h5}, '{timer_split_pkg::match2_addr, 1'b1, 32'h7, 32'h7},
    '{a_ien, 1'b1, 32'h1F, 32'h1F}, '{8'h04, 1'b1, 32'h55, 32'h0}};

  timer_split dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .standby_sleep(standby_sleep), .powerdown_sleep(powerdown_sleep), .event_input_a(ev_a),
    .event_input_b(ev_b), .events(events), .irq(irq));
  event_net_model model_u (.pclk(pclk), .presetn(presetn), .a_level(a_level), .b_level(b_level),
    .events(events), .event_input_a(ev_a), .event_input_b(ev_b), .wrap_seen(wrap_seen),
    .upper_seen(upper_seen), .match_seen(match_seen), .long_seen(long_seen));

  // ==========================================================================
  // clock and hang guard; the prescale sweep alone needs about 22000 cycles
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      stop_test();
    end
  end

  // ==========================================================================
  // bus and compare helpers; pready is waited for, never assumed
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    perr = pslverr;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask
  // count advance over access edges spaced n+3 cycles apart
  task automatic gap(input int n);
    logic [15:0] c0;
    rd(a_cnt);
    c0 = rdata[15:0];
    repeat (n) @(posedge pclk);
    rd(a_cnt);
    dc = rdata[15:0] - c0;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, standby_sleep, powerdown_sleep, a_level, b_level} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("irq after reset", 0, irq);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      check("register row", rows[i].e, rdata);
    end
    check("unmapped error", 1, perr);
    $display("test registers done");
    wr(a_ien, 32'h0);
    wr(a_per, 32'hF);
    wr(a_ctrl, 32'h1);
    repeat (40) @(posedge pclk);
    wr(a_ctrl, 32'h0);
    rd(a_flag); check("flags normal", 32'h1D, rdata);
    check("irq masked", 0, irq);
    check("no upper event", 0, upper_seen);
    check("wrap events", 1, wrap_seen > 0);
    check("match events", 1, match_seen >= 3);
    wr(a_ien, 32'h1); @(posedge pclk); check("irq raised", 1, irq);
    wr(a_flag, 32'h2); @(posedge pclk); check("irq held", 1, irq);
    wr(a_flag, 32'h1); @(posedge pclk); check("irq cleared", 0, irq);
    rd(a_flag); check("flags cleared", 32'h1C, rdata);
    wr(a_split, 32'h1); rd(a_per); check("period kept", 32'hF, rdata);
    wr(a_split, 32'h0);
    $display("test flags done");
    wr(a_per, 32'hFFFF);
    for (int i = 0; i < 8; i++) begin
      wr(a_ctrl, 32'(1 + 2 * i));
      gap(16 * divs[i] - 3); check("prescaled ticks", 32'd16, {16'h0, dc});
    end
    $display("test prescale done");
    wr(a_ctrl, 32'h1);
    standby_sleep <= 1'b1;
    repeat (4) @(posedge pclk);
    gap(10); check("standby halt", 0, {16'h0, dc});
    wr(a_ctrl, 32'h81); gap(10); check("standby run", 13, {16'h0, dc});
    powerdown_sleep <= 1'b1;
    repeat (4) @(posedge pclk);
    gap(10); check("powerdown halt", 0, {16'h0, dc});
    {standby_sleep, powerdown_sleep} <= 2'b00;
    $display("test sleep done");
    a_level <= 1'b1;
    wr(a_evc, 32'h09); repeat (6) @(posedge pclk); rd(a_cnt); check("a sets down", 1, rdata[16]);
    wr(a_evc, 32'h78); repeat (6) @(posedge pclk); rd(a_cnt); check("a gated", 0, rdata[16]);
    a_level <= 1'b0;
    b_level <= 1'b1;
    wr(a_evc, 32'h79); repeat (6) @(posedge pclk); rd(a_cnt); check("or down", 1, rdata[16]);
    wr(a_evc, 32'hD0); repeat (6) @(posedge pclk); rd(a_cnt); check("restart high", 0, rdata);
    wr(a_evc, 32'h03);
    repeat (3) begin
      a_level <= 1'b1;
      repeat (2) @(posedge pclk);
      a_level <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    rd(a_cnt); check("a counts edges", 3, rdata);
    $display("test event inputs done");
    wr(a_ctrl, 32'h0); wr(a_cmd, 32'hC);
    rd(a_per); check("hard reset", 32'hFFFF, rdata);
    up0 = upper_seen;
    wr(a_evc, 32'hD0);
    wr(a_split, 32'h1); wr(a_per, 32'h0304); wr(a_ctrl, 32'h1);
    repeat (20) @(posedge pclk);
    gap(10); check("split count moves", 1, dc != 16'h0);
    wr(a_ctrl, 32'h0);
    rd(a_flag); check("flags split", 32'h1F, rdata);
    check("upper events", 1, upper_seen > up0);
    check("one cycle pulses", 0, long_seen);
    $display("test split done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
